// >>> inc/ccs_pkg.sv
// ccs_pkg: timing counts, state codes and carrier structs for the clock-stop sequencer.
// assumes a single 20 MHz system clock; all pins arrive asynchronously.
`default_nettype none

package ccs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS        = 50;
  // bus clock counts as stopped after this long without an edge
  localparam int unsigned BCLK_IDLE_NS         = 1000;
  localparam int unsigned BCLK_IDLE_CYCLES     = (BCLK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least stopped interval the clock control owes us
  localparam int unsigned BCLK_MIN_STOP_NS     = 8000;
  localparam int unsigned BCLK_MIN_STOP_CYCLES = (BCLK_MIN_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLUSH_CYCLES         = 16;
  localparam int unsigned CNT_W                = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    CCS_OPERATING   = 4'h1,
    CCS_QUICK_START = 4'h2,
    CCS_SLEEP       = 4'h4,
    CCS_DEEP_SLEEP  = 4'h8
  } ccs_state_t;

  typedef struct packed {
    logic stop_clock_request_n;
    logic sleep_request_n;
    logic cache_flush_request_n;
  } ccs_pins_t;

  localparam ccs_pins_t PINS_IDLE = 3'h7;

  typedef struct packed {
    logic flush_pending;
    logic flush_active;
    logic flush_done;
    logic short_gap;
  } ccs_status_t;

  localparam ccs_status_t STATUS_RESET = 4'h0;

endpackage : ccs_pkg

`default_nettype wire

// >>> src/ccs_bus_clock_monitor.sv
// ccs_bus_clock_monitor: decides whether the bus clock pin is toggling.
// assumes the bus clock runs below half of sys_clk so every level is sampled.
`default_nettype none

module ccs_bus_clock_monitor (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic bus_clk_pin,
  output var  logic bus_clk_running
);

  logic                      meta_reg;
  logic                      sync_reg;
  logic                      last_reg;
  logic [ccs_pkg::CNT_W-1:0] idle_cnt_reg;
  logic [ccs_pkg::CNT_W-1:0] idle_cnt_next;
  logic                      running_reg;
  logic                      running_next;
  logic                      edge_seen;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    edge_seen     = sync_reg ^ last_reg;
    idle_cnt_next = idle_cnt_reg;
    running_next  = running_reg;
    if (edge_seen) begin
      idle_cnt_next = '0;
      running_next  = 1'b1;
    end else if (idle_cnt_reg == ccs_pkg::CNT_W'(ccs_pkg::BCLK_IDLE_CYCLES - 1)) begin
      running_next  = 1'b0;
    end else begin
      idle_cnt_next = idle_cnt_reg + ccs_pkg::CNT_W'(1);
    end
  end

  // starts as stopped so a sequencer never sees a phantom clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg     <= 1'b0;
      sync_reg     <= 1'b0;
      last_reg     <= 1'b0;
      idle_cnt_reg <= '0;
      running_reg  <= 1'b0;
    end else begin
      meta_reg     <= bus_clk_pin;
      sync_reg     <= meta_reg;
      last_reg     <= sync_reg;
      idle_cnt_reg <= idle_cnt_next;
      running_reg  <= running_next;
    end
  end

  assign bus_clk_running = running_reg;

endmodule : ccs_bus_clock_monitor

`default_nettype wire

// >>> src/ccs_clock_stop_sequencer.sv
// ccs_clock_stop_sequencer: quick start, sleep and deep sleep sequencing plus cache flush deferral.
// assumes request pins are asynchronous and active low; bus clock pin is sampled, not used as a clock.
`default_nettype none

module ccs_clock_stop_sequencer (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire ccs_pkg::ccs_pins_t  pins,
  input  wire logic                bus_clk_pin,
  output var  ccs_pkg::ccs_state_t cpu_state,
  output var  ccs_pkg::ccs_status_t status
);

  ccs_pkg::ccs_pins_t        pins_meta_reg;
  ccs_pkg::ccs_pins_t        pins_sync_reg;
  ccs_pkg::ccs_pins_t        pins_last_reg;
  ccs_pkg::ccs_state_t       state_reg;
  ccs_pkg::ccs_state_t       state_next;
  logic                      flush_pending_reg;
  logic                      flush_pending_next;
  logic                      flush_active_reg;
  logic                      flush_active_next;
  logic                      flush_done_reg;
  logic                      flush_done_next;
  logic [ccs_pkg::CNT_W-1:0] flush_cnt_reg;
  logic [ccs_pkg::CNT_W-1:0] flush_cnt_next;
  logic [ccs_pkg::CNT_W-1:0] stop_cnt_reg;
  logic [ccs_pkg::CNT_W-1:0] stop_cnt_next;
  logic                      short_gap_reg;
  logic                      short_gap_next;
  logic                      bus_running;
  logic                      stop_active;
  logic                      sleep_active;
  logic                      flush_edge;
  logic                      flush_start;
  logic                      flush_busy;

  ////////////////////////////////////////////////////////////////////////////
  ccs_bus_clock_monitor u_bus_clock_monitor (
    .sys_clk         (sys_clk),
    .arst_n          (arst_n),
    .bus_clk_pin     (bus_clk_pin),
    .bus_clk_running (bus_running)
  );

  // last copy feeds the flush edge detector, never the first stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_meta_reg <= ccs_pkg::PINS_IDLE;
      pins_sync_reg <= ccs_pkg::PINS_IDLE;
      pins_last_reg <= ccs_pkg::PINS_IDLE;
    end else begin
      pins_meta_reg <= pins;
      pins_sync_reg <= pins_meta_reg;
      pins_last_reg <= pins_sync_reg;
    end
  end

  always_comb begin
    stop_active  = ~pins_sync_reg.stop_clock_request_n;
    sleep_active = ~pins_sync_reg.sleep_request_n;
    flush_edge   = pins_last_reg.cache_flush_request_n & ~pins_sync_reg.cache_flush_request_n;
    flush_busy   = flush_pending_reg | flush_active_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // flush engine
  always_comb begin
    flush_pending_next = flush_pending_reg;
    flush_active_next  = flush_active_reg;
    flush_cnt_next     = flush_cnt_reg;
    flush_done_next    = 1'b0;
    flush_start = flush_pending_reg & ~flush_active_reg & ~stop_active &
                  (state_reg == ccs_pkg::CCS_OPERATING);
    if (flush_start) begin
      flush_pending_next = 1'b0;
      flush_active_next  = 1'b1;
      flush_cnt_next     = '0;
    end else if (flush_active_reg) begin
      if (flush_cnt_reg == ccs_pkg::CNT_W'(ccs_pkg::FLUSH_CYCLES - 1)) begin
        flush_active_next = 1'b0;
        flush_done_next   = 1'b1;
      end else begin
        flush_cnt_next = flush_cnt_reg + ccs_pkg::CNT_W'(1);
      end
    end
    // a new request beats the clear of the same cycle
    if (flush_edge) begin
      flush_pending_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flush_pending_reg <= 1'b0;
      flush_active_reg  <= 1'b0;
      flush_done_reg    <= 1'b0;
      flush_cnt_reg     <= '0;
    end else begin
      flush_pending_reg <= flush_pending_next;
      flush_active_reg  <= flush_active_next;
      flush_done_reg    <= flush_done_next;
      flush_cnt_reg     <= flush_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ccs_pkg::CCS_OPERATING: begin
        // a running flush finishes first; a pending one is deferred
        if (stop_active && !flush_active_reg) begin
          state_next = ccs_pkg::CCS_QUICK_START;
        end
      end
      ccs_pkg::CCS_QUICK_START: begin
        if (!bus_running) begin
          state_next = ccs_pkg::CCS_DEEP_SLEEP;
        end else if (!stop_active) begin
          state_next = ccs_pkg::CCS_OPERATING;
        end else if (sleep_active && !flush_busy) begin
          state_next = ccs_pkg::CCS_SLEEP;
        end
      end
      ccs_pkg::CCS_SLEEP: begin
        if (!bus_running) begin
          state_next = ccs_pkg::CCS_DEEP_SLEEP;
        end else if (!sleep_active) begin
          state_next = ccs_pkg::CCS_QUICK_START;
        end
      end
      ccs_pkg::CCS_DEEP_SLEEP: begin
        if (bus_running) begin
          state_next = ccs_pkg::CCS_QUICK_START;
        end
      end
      default: begin
        state_next = ccs_pkg::CCS_OPERATING;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ccs_pkg::CCS_OPERATING;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stopped interval watch: the exit itself is never refused, only reported
  always_comb begin
    stop_cnt_next  = stop_cnt_reg;
    short_gap_next = short_gap_reg;
    if (state_reg != ccs_pkg::CCS_DEEP_SLEEP) begin
      stop_cnt_next = '0;
    end else if (bus_running) begin
      short_gap_next = (stop_cnt_reg < ccs_pkg::CNT_W'(ccs_pkg::BCLK_MIN_STOP_CYCLES));
    end else if (stop_cnt_reg != ccs_pkg::CNT_W'(ccs_pkg::BCLK_MIN_STOP_CYCLES)) begin
      stop_cnt_next = stop_cnt_reg + ccs_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_cnt_reg  <= '0;
      short_gap_reg <= 1'b0;
    end else begin
      stop_cnt_reg  <= stop_cnt_next;
      short_gap_reg <= short_gap_next;
    end
  end

  always_comb begin
    cpu_state            = state_reg;
    status.flush_pending = flush_pending_reg;
    status.flush_active  = flush_active_reg;
    status.flush_done    = flush_done_reg;
    status.short_gap     = short_gap_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_QS_CLOCK_LOSS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_reg == ccs_pkg::CCS_QUICK_START) && !bus_running |=> state_reg == ccs_pkg::CCS_DEEP_SLEEP
  ) else $error("quick start did not enter deep sleep on clock loss");

  AST_DEEP_RESTART: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_reg == ccs_pkg::CCS_DEEP_SLEEP) && bus_running |=> state_reg == ccs_pkg::CCS_QUICK_START
  ) else $error("deep sleep did not return to quick start");

  AST_FLUSH_DEFERRED: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(flush_active_reg) |-> !$past(stop_active) && $past(state_reg) == ccs_pkg::CCS_OPERATING
  ) else $error("flush started while stop-clock was asserted");

  AST_SLEEP_NO_FLUSH: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    state_reg == ccs_pkg::CCS_QUICK_START ##1 state_reg == ccs_pkg::CCS_SLEEP
      |-> !$past(flush_pending_reg) && !$past(flush_active_reg)
  ) else $error("sleep entered with a flush outstanding");

  AST_SLEEP_CLOCK_LOSS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_reg == ccs_pkg::CCS_SLEEP) && !bus_running |=> state_reg == ccs_pkg::CCS_DEEP_SLEEP
  ) else $error("sleep did not enter deep sleep on clock loss");

  AST_ONE_STATE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $onehot(state_reg)
  ) else $error("state is not one-hot");

  AST_DEEP_HOLDS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (state_reg == ccs_pkg::CCS_DEEP_SLEEP) && !bus_running |=> state_reg == ccs_pkg::CCS_DEEP_SLEEP
  ) else $error("deep sleep left without a clock restart");

  AST_FLUSH_LENGTH: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(flush_active_reg) |-> ##16 (flush_done_reg && !flush_active_reg)
  ) else $error("flush did not run its fixed length");

  // counter stands in for a long repetition of the active level
  AST_FLUSH_HOLDS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    flush_active_reg && (flush_cnt_reg != ccs_pkg::CNT_W'(ccs_pkg::FLUSH_CYCLES - 1)) |=> flush_active_reg
  ) else $error("flush stopped before its last count");

endmodule : ccs_clock_stop_sequencer

`default_nettype wire

// >>> bench/ccs_clock_ctrl_model.sv
// ccs_clock_ctrl_model: chipset side clock control that gates the bus clock.
// assumes the bench drives the halt control; a stopped bus clock idles low.
`default_nettype none

module ccs_clock_ctrl_model #(
  // margin beyond the minimum stop covers the sequencer's idle detector
  parameter realtime MIN_STOP_NS = 9500.0
) (
  input  wire logic cpu_clock_halt_control_n,
  input  wire logic allow_short_gap,
  output wire logic bus_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  realtime stopped_at;
  logic    clk_q = 1'b0;

  assign bus_clk_pin = clk_q;

  always begin
    if (cpu_clock_halt_control_n) begin
      #150 clk_q = ~clk_q;
    end else begin
      clk_q = 1'b0;
      stopped_at = $realtime;
      wait (cpu_clock_halt_control_n);
      if (!allow_short_gap && ($realtime - stopped_at) < MIN_STOP_NS) begin
        #(MIN_STOP_NS - ($realtime - stopped_at));
      end
    end
  end
endmodule : ccs_clock_ctrl_model

`default_nettype wire

// >>> bench/cpu_clock_stop_state_sequencer_tb.sv
// cpu_clock_stop_state_sequencer_tb: directed scenarios for the clock-stop sequencer.
// assumes the clock control model gates the bus clock; pins change on falling edges.
`default_nettype none

module cpu_clock_stop_state_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 sys_clk                  = 1'b0;
  logic                 arst_n                   = 1'b0;
  ccs_pkg::ccs_pins_t   pins                     = ccs_pkg::PINS_IDLE;
  logic                 cpu_clock_halt_control_n = 1'b1;
  logic                 allow_short_gap          = 1'b0;
  logic                 bus_clk_pin;
  ccs_pkg::ccs_state_t  cpu_state;
  ccs_pkg::ccs_status_t status;
  int                   errors                   = 0;
  int                   tests_run                = 0;
  int                   cycles                   = 0;

  always #25 sys_clk = ~sys_clk;

  ccs_clock_stop_sequencer i_ccs_clock_stop_sequencer (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .pins       (pins),
    .bus_clk_pin(bus_clk_pin),
    .cpu_state  (cpu_state),
    .status     (status)
  );

  ccs_clock_ctrl_model i_ccs_clock_ctrl_model (
    .cpu_clock_halt_control_n(cpu_clock_halt_control_n),
    .allow_short_gap         (allow_short_gap),
    .bus_clk_pin             (bus_clk_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // sel 0 watches the state, sel 1 the masked status; bounded so a hang fails
  task automatic wait_for(input bit sel, input logic [3:0] mask, input logic [3:0] exp, input int bound);
    logic [3:0] v;
    v = 4'h0;
    repeat (bound) begin
      @(negedge sys_clk);
      v = (sel ? 4'(status) : 4'(cpu_state)) & mask;
      if (v === exp) break;
    end
    check(v, exp);
  endtask : wait_for

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(4'(cpu_state), 4'(ccs_pkg::CCS_OPERATING));
    check(4'(status), 4'(ccs_pkg::STATUS_RESET));
  endtask : t_reset

  task automatic t_flush_plain();
    pins.cache_flush_request_n = 1'b0;
    wait_for(1'b1, 4'h4, 4'h4, 10);
    wait_for(1'b1, 4'h2, 4'h2, 30);
    check(4'(cpu_state), 4'(ccs_pkg::CCS_OPERATING));
    pins.cache_flush_request_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : t_flush_plain

  // flush raised under stop-clock on purpose, then sleep asked for
  task automatic t_deferred_flush();
    pins.stop_clock_request_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_QUICK_START), 10);
    pins.cache_flush_request_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(4'(status) & 4'hc, 4'h8);
    pins.sleep_request_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(4'(cpu_state), 4'(ccs_pkg::CCS_QUICK_START));
    pins.sleep_request_n = 1'b1;
    pins.stop_clock_request_n = 1'b1;
    wait_for(1'b1, 4'h4, 4'h4, 10);
    wait_for(1'b1, 4'h2, 4'h2, 30);
    check(4'(cpu_state), 4'(ccs_pkg::CCS_OPERATING));
    pins.cache_flush_request_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : t_deferred_flush

  task automatic t_sleep_deep();
    pins.stop_clock_request_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_QUICK_START), 10);
    pins.sleep_request_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_SLEEP), 10);
    pins.sleep_request_n = 1'b1;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_QUICK_START), 10);
    pins.sleep_request_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_SLEEP), 10);
    cpu_clock_halt_control_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_DEEP_SLEEP), 60);
    pins.sleep_request_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    cpu_clock_halt_control_n = 1'b1;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_QUICK_START), 260);
    check(4'(status) & 4'h1, 4'h0);
  endtask : t_sleep_deep

  // bus clock restarted early: exit still happens, gap flagged
  task automatic t_quick_deep_short();
    cpu_clock_halt_control_n = 1'b0;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_DEEP_SLEEP), 60);
    allow_short_gap = 1'b1;
    repeat (10) @(negedge sys_clk);
    cpu_clock_halt_control_n = 1'b1;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_QUICK_START), 20);
    check(4'(status) & 4'h1, 4'h1);
    allow_short_gap = 1'b0;
    pins.stop_clock_request_n = 1'b1;
    wait_for(1'b0, 4'hf, 4'(ccs_pkg::CCS_OPERATING), 10);
  endtask : t_quick_deep_short

  initial begin
    repeat (10) @(negedge sys_clk);
    t_reset();
    arst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    t_flush_plain();
    t_deferred_flush();
    t_sleep_deep();
    t_quick_deep_short();
    tally_and_finish();
  end
endmodule : cpu_clock_stop_state_sequencer_tb

`default_nettype wire
